// ===== rtl/ulpi_interface_control_reg.sv
// interface control register of the ulpi transceiver, with its effects
// assumes register requests come from ulpi logic on SYS_CLK_I; the stop
// pin and fault input come from outside and are synchronised here
//
// Operation
// RULE1: link enables at most one alternative interface mode at a time
// RULE2: reads at 07h-09h; write 07h plain, 08h set, 09h clear
// RULE3: set address ors ones in, clear address clears them, rest kept
// RULE4: bit7 low: stop pull-up; stop unexpectedly high adds data pull-downs
// RULE5: with protection on, detect link no longer driving stop
// RULE6: bit7 high removes stop pull-up and data pull-downs
// RULE7: link always programs bit6 to one
// RULE8: fault complement never qualified with vbus comparator
// RULE9: bit5 high inverts fault input, low passes it straight
// RULE10: bit3 active-low clock suspend: one keeps clock on in serial
// RULE11: clock suspend bit ignored unless serial mode and phy awake
// RULE12: bit1 high carries fs/ls packets over 3-wire serial interface
// RULE13: device clears serial mode bit when leaving serial mode
// RULE14: phy_awake_n low is suspend; stop exits and device sets it back
`timescale 1ns/100ps
`default_nettype none
`include "ifc_ctrl_regs.svh"

module ulpi_interface_control_reg #(
  parameter int SYNC_STAGES = 3
) (
  // clock, reset, enable
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RST_B_I,
  input  wire logic                  CLK_EN_I,
  // register port
  input  wire ifc_ctrl_pkg::reg_req_s REQ_I,
  output logic                       RD_HIT_O,
  output logic [7:0]                 RDATA_O,
  // pins and device status
  input  wire logic                  STOP_PIN_I,
  input  wire logic                  FAULT_PIN_I,
  input  wire logic                  PHY_AWAKE_N_I,
  input  wire logic                  SERIAL_EXIT_I,
  input  wire logic                  STOP_EXPECTED_I,
  input  wire logic                  VBUS_VALID_COMPARATOR_I,
  // effects
  output ifc_ctrl_pkg::guard_s       GUARD_O,
  output logic                       FAULT_COMPL_O,
  output logic                       CLOCK_POWERED_O,
  output logic                       THREE_WIRE_SERIAL_MODE_O,
  output logic [7:0]                 CTRL_O
);
  import ifc_ctrl_pkg::*;

  // three stages are wired below; refuse any other count
  if (SYNC_STAGES != 3) begin : g_bad_sync_stages
    $error("SYNC_STAGES must be 3");
  end

  // ----------------------------------------------------------------------
  // pin synchronisers, second and third stage must agree
  // ----------------------------------------------------------------------
  logic [2:0] stop_sync;
  logic [2:0] fault_sync;
  logic       stop_s;
  logic       fault_s;

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      stop_sync  <= 3'h7;
      fault_sync <= 3'h0;
      stop_s     <= 1'b1;
      fault_s    <= 1'b0;
    end else if (CLK_EN_I) begin
      stop_sync  <= {stop_sync[1:0], STOP_PIN_I};
      fault_sync <= {fault_sync[1:0], FAULT_PIN_I};
      if (stop_sync[1] == stop_sync[2]) begin
        stop_s <= stop_sync[2];
      end
      if (fault_sync[1] == fault_sync[2]) begin
        fault_s <= fault_sync[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  wire        hit_wr  = REQ_I.addr == `IFC_ADDR_WRITE; // RULE2
  wire        hit_set = REQ_I.addr == `IFC_ADDR_SET;
  wire        hit_clr = REQ_I.addr == `IFC_ADDR_CLEAR;
  wire        hit_any = hit_wr | hit_set | hit_clr;
  wr_kind_e   wr_kind;

  assign wr_kind = !REQ_I.wr ? WR_NONE :
                   hit_wr    ? WR_PLAIN :
                   hit_set   ? WR_SET :
                   hit_clr   ? WR_CLEAR : WR_NONE;

  wire serial_bit = ctrl[`IFC_BIT_SERIAL];

  always_comb begin
    next_ctrl = ctrl;
    case (wr_kind)
      WR_PLAIN: next_ctrl = REQ_I.wdata;
      WR_SET:   next_ctrl = ctrl | REQ_I.wdata; // RULE3
      WR_CLEAR: next_ctrl = ctrl & ~REQ_I.wdata; // RULE3
      WR_NONE:  next_ctrl = ctrl;
      default:  next_ctrl = ctrl;
    endcase
    if (SERIAL_EXIT_I && serial_bit) begin
      next_ctrl[`IFC_BIT_SERIAL] = 1'b0; // RULE13
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl <= `IFC_RESET_VALUE;
    end else if (CLK_EN_I) begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RD_HIT_O <= 1'b0;
      RDATA_O  <= 8'h00;
    end else if (CLK_EN_I) begin
      RD_HIT_O <= REQ_I.rd & hit_any; // RULE2
      RDATA_O  <= (REQ_I.rd & hit_any) ? ctrl : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // effects of the register bits
  // ----------------------------------------------------------------------
  wire guard_on = ~ctrl[`IFC_BIT_GUARD_OFF];
  wire in_serial = serial_bit;

  wire stop_stray = guard_on & stop_s & ~STOP_EXPECTED_I; // RULE4 RULE5
  assign GUARD_O = '{stop_pullup:   guard_on,    // RULE4 RULE6
                     data_pulldown: stop_stray,  // RULE4
                     stop_released: stop_stray}; // RULE5
  // comparator deliberately unused: fault passes unqualified
  wire unused_cmp = VBUS_VALID_COMPARATOR_I; // RULE8
  assign FAULT_COMPL_O = fault_s ^ ctrl[`IFC_BIT_INVERT]; // RULE9
  // clock suspend only meaningful in serial mode while awake
  assign CLOCK_POWERED_O = !in_serial || !PHY_AWAKE_N_I ||
                           ctrl[`IFC_BIT_CLOCK_ON]; // RULE10 RULE11 RULE14
  assign THREE_WIRE_SERIAL_MODE_O = in_serial; // RULE12
  assign CTRL_O = ctrl;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_plain_write;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (CLK_EN_I && REQ_I.wr && hit_wr && !SERIAL_EXIT_I)
      |=> ctrl == $past(REQ_I.wdata);
  endproperty
  a_plain_write: assert property (p_plain_write) // RULE2
    else $error("plain write not stored");

  property p_set_write;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (CLK_EN_I && REQ_I.wr && hit_set && !SERIAL_EXIT_I)
      |=> ctrl == ($past(ctrl) | $past(REQ_I.wdata));
  endproperty
  a_set_write: assert property (p_set_write) // RULE3
    else $error("set write wrong");

  property p_clr_write;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (CLK_EN_I && REQ_I.wr && hit_clr && !SERIAL_EXIT_I)
      |=> ctrl == ($past(ctrl) & ~$past(REQ_I.wdata));
  endproperty
  a_clr_write: assert property (p_clr_write) // RULE3
    else $error("clear write wrong");

  property p_read_back;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (CLK_EN_I && REQ_I.rd && hit_any)
      |=> RD_HIT_O && RDATA_O == $past(ctrl);
  endproperty
  a_read_back: assert property (p_read_back) // RULE2
    else $error("read back wrong");

  property p_guard;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      ctrl[`IFC_BIT_GUARD_OFF]
      |-> !GUARD_O.stop_pullup && !GUARD_O.data_pulldown;
  endproperty
  a_guard: assert property (p_guard) // RULE6
    else $error("guard active while disabled");

  property p_fault;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (CLK_EN_I && fault_sync[1] == fault_sync[2])
      |=> FAULT_COMPL_O == ($past(fault_sync[2]) ^ ctrl[`IFC_BIT_INVERT]);
  endproperty
  a_fault: assert property (p_fault) // RULE9
    else $error("fault complement wrong");

  property p_serial_exit;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (CLK_EN_I && SERIAL_EXIT_I && !REQ_I.wr) |=> !ctrl[`IFC_BIT_SERIAL];
  endproperty
  a_serial_exit: assert property (p_serial_exit) // RULE13
    else $error("serial bit not cleared on exit");

  property p_clock_ignored;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (!in_serial || !PHY_AWAKE_N_I) |-> CLOCK_POWERED_O;
  endproperty
  a_clock_ignored: assert property (p_clock_ignored) // RULE11
    else $error("clock suspend not ignored");

  property p_refused;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (CLK_EN_I && !(REQ_I.rd && hit_any)) |=> !RD_HIT_O;
  endproperty
  a_refused: assert property (p_refused) // RULE2
    else $error("read answered without a hit");

  property p_hold;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (!CLK_EN_I || (!REQ_I.wr && !SERIAL_EXIT_I)) |=> ctrl == $past(ctrl);
  endproperty
  a_hold: assert property (p_hold) // RULE3
    else $error("register changed without a write");

  property p_clock_suspend;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (in_serial && PHY_AWAKE_N_I && !ctrl[`IFC_BIT_CLOCK_ON])
      |-> !CLOCK_POWERED_O;
  endproperty
  a_clock_suspend: assert property (p_clock_suspend) // RULE10
    else $error("clock powered while suspended in serial mode");

endmodule : ulpi_interface_control_reg

`default_nettype wire

// ===== rtl/ifc_ctrl_regs.svh
// interface control register: offsets, bit positions, reset value
// assumes inclusion by bare name from the design module
`ifndef IFC_CTRL_REGS_SVH
`define IFC_CTRL_REGS_SVH

// ----------------------------------------------------------------------
// register addresses (6-bit register address space)
// ----------------------------------------------------------------------
`define IFC_ADDR_WRITE      6'h07
`define IFC_ADDR_SET        6'h08
`define IFC_ADDR_CLEAR      6'h09

// ----------------------------------------------------------------------
// bit positions and reset value
// ----------------------------------------------------------------------
`define IFC_BIT_GUARD_OFF   7
`define IFC_BIT_UNQUAL      6
`define IFC_BIT_INVERT      5
`define IFC_BIT_CLOCK_ON    3
`define IFC_BIT_SERIAL      1
`define IFC_RESET_VALUE     8'h00

`endif

// ===== rtl/ifc_ctrl_pkg.sv
// types shared by the interface control register
// assumes it is compiled before the design module and the bench
package ifc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register access request from the ulpi register port
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // ----------------------------------------------------------------------
  // pin-protection controls toward the pad ring
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic stop_pullup;
    logic data_pulldown;
    logic stop_released;
  } guard_s;

  typedef enum logic [1:0] {
    WR_PLAIN = 2'b00,
    WR_SET   = 2'b01,
    WR_CLEAR = 2'b10,
    WR_NONE  = 2'b11
  } wr_kind_e;

endpackage : ifc_ctrl_pkg

// ===== testbench/link_model.sv
// link controller model: drives or releases the stop line
// assumes the device guard pull-up sets a released line's level
`timescale 1ns/100ps
`default_nettype none

module link_model (
  // link side
  input  wire logic drive_i,
  input  wire logic level_i,
  input  wire logic pullup_i,
  // pin
  output logic      stop_o
);
  logic last;

  always_latch begin
    if (drive_i) last <= level_i;
  end

  // floating line reads one while the guard pull-up is on, else the inverse of its last driven level
  assign stop_o = drive_i ? level_i : (pullup_i ? 1'b1 : ~last);
endmodule : link_model

`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the interface control register
// assumes ifc_ctrl_pkg is compiled first
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ifc_ctrl_pkg::*;
  logic       clk = 0, rst_b = 0, hit, compl, pwr, ser;
  logic       flt = 0, awake = 1, ext = 0, exp_stp = 0, vb = 0;
  logic       drv = 1, lvl = 0, stp, en = 1;
  logic [7:0] rdat, ctrl;
  reg_req_s   req = '0;
  guard_s     grd;
  int         error_cnt = 0, n_checks = 0;

  ulpi_interface_control_reg u_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b),
    .CLK_EN_I(en), .REQ_I(req), .RD_HIT_O(hit), .RDATA_O(rdat),
    .STOP_PIN_I(stp), .FAULT_PIN_I(flt), .PHY_AWAKE_N_I(awake),
    .SERIAL_EXIT_I(ext), .STOP_EXPECTED_I(exp_stp),
    .VBUS_VALID_COMPARATOR_I(vb), .GUARD_O(grd), .FAULT_COMPL_O(compl),
    .CLOCK_POWERED_O(pwr), .THREE_WIRE_SERIAL_MODE_O(ser), .CTRL_O(ctrl));

  link_model u_link (.drive_i(drv), .level_i(lvl),
    .pullup_i(grd.stop_pullup), .stop_o(stp));

  initial forever #25 clk = ~clk;

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk) req = '{1'b1, 1'b0, a, d};
    @(negedge clk) req = '0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] d, input logic h);
    @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req = '0;
    check("rd_hit", 8'(hit), 8'(h));
    check("rdata", rdat, d);
  endtask : rd

  task automatic settle();
    repeat (8) @(negedge clk);
  endtask : settle

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    check("ctrl", ctrl, 8'h00);
    check("pullup", 8'(grd.stop_pullup), 8'h01);
    check("serial", 8'(ser), 8'h00);
    check("clk_pwr", 8'(pwr), 8'h01);
    check("rd_hit", 8'(hit), 8'h00);
    check("rdata", rdat, 8'h00);
  endtask : t_reset

  task automatic t_rw();
    wr(6'h07, 8'h42);
    check("serial", 8'(ser), 8'h01);
    for (int a = 7; a <= 9; a++) rd(6'(a), 8'h42, 1'b1);
    rd(6'h0a, 8'h00, 1'b0);
  endtask : t_rw

  task automatic t_setclr();
    wr(6'h08, 8'h28);
    check("ctrl", ctrl, 8'h6a);
    wr(6'h09, 8'h02);
    check("ctrl", ctrl, 8'h68);
  endtask : t_setclr

  task automatic t_fault();
    flt = 1'b1;
    settle();
    check("compl", 8'(compl), 8'h00);
    vb = 1'b1;
    settle();
    check("compl", 8'(compl), 8'h00);
    wr(6'h09, 8'h20);
    check("compl", 8'(compl), 8'h01);
  endtask : t_fault

  task automatic t_clock();
    check("clk_pwr", 8'(pwr), 8'h01);
    wr(6'h07, 8'h42);
    check("clk_pwr", 8'(pwr), 8'h00);
    @(negedge clk) awake = 1'b0;
    @(negedge clk);
    check("clk_pwr", 8'(pwr), 8'h01);
    awake = 1'b1;
    wr(6'h08, 8'h08);
    check("clk_pwr", 8'(pwr), 8'h01);
    @(negedge clk) ext = 1'b1;
    @(negedge clk) ext = 1'b0;
    check("ctrl", ctrl, 8'h48);
  endtask : t_clock

  task automatic t_guard();
    drv = 1'b0;
    settle();
    check("pulldown", 8'(grd.data_pulldown), 8'h01);
    check("released", 8'(grd.stop_released), 8'h01);
    exp_stp = 1'b1;
    @(negedge clk);
    check("pulldown", 8'(grd.data_pulldown), 8'h00);
    check("released", 8'(grd.stop_released), 8'h00);
    exp_stp = 1'b0;
    wr(6'h08, 8'h80);
    check("pullup", 8'(grd.stop_pullup), 8'h00);
    check("pulldown", 8'(grd.data_pulldown), 8'h00);
    check("released", 8'(grd.stop_released), 8'h00);
  endtask : t_guard

  task automatic t_freeze();
    @(negedge clk) en = 1'b0;
    wr(6'h07, 8'h02);
    rd(6'h08, 8'h00, 1'b0);
    check("ctrl", ctrl, 8'hc8);
    @(negedge clk) en = 1'b1;
    rd(6'h08, 8'hc8, 1'b1);
  endtask : t_freeze

  task automatic t_midreset();
    @(negedge clk) rst_b = 1'b0;
    @(negedge clk) rst_b = 1'b1;
    t_reset();
  endtask : t_midreset

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    t_reset();
    t_rw();
    t_setclr();
    t_fault();
    t_clock();
    t_guard();
    t_freeze();
    t_midreset();
    end_of_test();
  end

  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
